// >>> pin_ctrl_pkg.sv
// Package for the output pin and handshake controller.
// Assumes a 125 MHz system clock and AHB-Lite register access.
package pin_ctrl_pkg;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_TMO    = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_MSG    = 8'h10;
  localparam logic [7:0] OFF_TXCHAR = 8'h14;
  // Control register fields
  localparam int CTRL_BUSY_MODE = 0;
  localparam int CTRL_POS_LOGIC = 1;
  localparam int CTRL_XON_MODE  = 2;
  // Command codes written to OFF_CMD
  localparam logic [3:0] CMD_ON      = 4'h1;
  localparam logic [3:0] CMD_OFF     = 4'h2;
  localparam logic [3:0] CMD_TOGGLE  = 4'h3;
  localparam logic [3:0] CMD_LOCK    = 4'h4;
  localparam logic [3:0] CMD_UNLOCK  = 4'h5;
  localparam logic [3:0] CMD_RUN_DEF = 4'h6;
  localparam logic [3:0] CMD_RUN_NEW = 4'h7;
  localparam logic [3:0] CMD_RESUME  = 4'h8;
  localparam logic [3:0] CMD_HALT    = 4'h9;
  // Timeout value layout: range in [9:8], count 1..63 in [5:0]
  localparam logic [1:0] RANGE_10MS = 2'h0;
  localparam logic [1:0] RANGE_SEC  = 2'h1;
  localparam logic [1:0] RANGE_MIN  = 2'h2;
  localparam logic [5:0] TMO_MIN_CNT = 6'h01;
  localparam logic [5:0] TMO_MAX_CNT = 6'h3F;
  // Time base: one tick per 10 ms
  localparam int TICK_NS     = 10000000;
  localparam int CLK_NS      = 8;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam logic [12:0] TICKS_PER_SEC = 13'h0064;
  localparam logic [12:0] TICKS_PER_MIN = 13'h1770;
  // Flow-control characters, then the reset default interval
  localparam logic [7:0] CHAR_XOFF = 8'h13;
  localparam logic [7:0] CHAR_XON  = 8'h11;
  localparam logic [9:0] TMO_RESET = 10'h001;
endpackage : pin_ctrl_pkg

// >>> output_pin_handshake_ctrl.sv
// Output pin and ready/busy / XON-XOFF handshake controller, AHB-Lite slave.
// Assumes message/command parsing lives elsewhere; it pulses msg_start and
// msg_done around each string and writes embedded pin requests to the registers.
// Operation
// - Pin works either as ready/busy indicator or as command-driven output.
// - One polarity setting governs the pin in both modes.
// - Negative polarity conducts when on or busy; positive conducts when off or ready.
// - Output mode accepts on, off and toggle requests.
// - While locked every pin configuration request is dropped until unlock.
// - Timeout has run and halt states; halted it has no effect.
// - Starting the timeout leaves the pin state unchanged.
// - Expiry of a running timeout turns the pin off.
// - Timeout starts from default, supplied value, or halted remainder.
// - Intervals span 20-1260 ms, 1-63 s, 1 min; larger minute counts wrap the 13-bit remainder.
// - Embedded pin configuration is a control code plus three digits.
// - Embedded timeout request is a control code plus three-digit interval.
// - Handshake selectable: XON/XOFF characters or ready/busy pin.
// - XON/XOFF sends 13h on busy and 11h on ready.
// - Each message sends XOFF; XON follows when processing ends.
// - XON/XOFF selected forces error code reporting on.
// - Busy mode drives pin busy on busy, ready on ready.
// - Each received string sets busy until fully processed.
`timescale 1ns/10ps
module output_pin_handshake_ctrl #(
  parameter int TICK_CYC = pin_ctrl_pkg::TICK_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        msg_start,
  input  wire logic        msg_done,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic      [7:0]  tx_char,
  output logic             err_report_force,
  output logic             pin_oe
);
  typedef struct packed {
    logic        wr_pend;
    logic        rd_pend;
    logic [7:0]  addr;
    logic [31:0] rdata;
    logic [2:0]  ctrl;
    logic [9:0]  tmo_default;
    logic        pin_on;
    logic        locked;
    logic        tmo_run;
    logic [12:0] remain;
    logic [31:0] presc;
    logic        busy;
    logic        tx_valid;
    logic [7:0]  tx_char;
    logic        tx_pend_busy;
    logic        tx_pend_ready;
    logic        pin_oe;
    logic        err_force;
  } state_s;

  state_s cur;
  state_s nxt;

  // three interval ranges
  // Interval value to 10 ms ticks; count clamped into 1..63
  function automatic logic [12:0] to_ticks(input logic [9:0] v);
    logic [5:0]  n;
    logic [12:0] r;
    n = v[5:0];
    if (n < pin_ctrl_pkg::TMO_MIN_CNT) n = pin_ctrl_pkg::TMO_MIN_CNT;
    case (v[9:8])
      pin_ctrl_pkg::RANGE_SEC: r = 13'({7'h00, n} * pin_ctrl_pkg::TICKS_PER_SEC);
      pin_ctrl_pkg::RANGE_MIN: r = 13'({7'h00, n} * pin_ctrl_pkg::TICKS_PER_MIN);
      default:                 r = {7'h00, n} + {7'h00, n};
    endcase
    return r;
  endfunction : to_ticks

  // Valid address phase: selected, bus ready, NONSEQ or SEQ
  function automatic logic bus_take(input logic sel, input logic rdy, input logic [1:0] trans);
    return sel && rdy && trans[1];
  endfunction : bus_take

  logic        wr_ok;
  logic        tick;
  logic [3:0]  cmd;
  logic        pin_busy_level;

  always_comb begin
    nxt       = cur;
    wr_ok     = cur.wr_pend;
    cmd       = hwdata[3:0];
    tick      = (cur.presc == 32'(TICK_CYC - 1));
    // Address phase capture; always zero wait states
    nxt.wr_pend = bus_take(hsel, hready, htrans) && hwrite;
    nxt.rd_pend = bus_take(hsel, hready, htrans) && !hwrite;
    if (bus_take(hsel, hready, htrans))
      nxt.addr = haddr[7:0];
    nxt.presc = tick ? 32'h00000000 : cur.presc + 32'h00000001;

    // Timeout countdown while running
    if (cur.tmo_run && tick) begin
      if (cur.remain <= 13'h0001) begin
        nxt.pin_on  = 1'b0;
        nxt.tmo_run = 1'b0;
        nxt.remain  = 13'h0000;
      end else begin
        nxt.remain = cur.remain - 13'h0001;
      end
    end

    if (wr_ok) begin
      case (cur.addr)
        pin_ctrl_pkg::OFF_CTRL: begin
          // lock blocks mode and polarity changes
          if (!cur.locked) nxt.ctrl = hwdata[2:0];
        end
        pin_ctrl_pkg::OFF_TMO: begin
          if (!cur.locked) nxt.tmo_default = hwdata[9:0];
        end
        pin_ctrl_pkg::OFF_CMD: begin
          if (cmd == pin_ctrl_pkg::CMD_UNLOCK) begin
            nxt.locked = 1'b0;
          end else if (!cur.locked) begin
            case (cmd)
              pin_ctrl_pkg::CMD_ON:     nxt.pin_on = 1'b1;
              pin_ctrl_pkg::CMD_OFF:    nxt.pin_on = 1'b0;
              pin_ctrl_pkg::CMD_TOGGLE: nxt.pin_on = !cur.pin_on;
              pin_ctrl_pkg::CMD_LOCK:   nxt.locked = 1'b1;
              pin_ctrl_pkg::CMD_RUN_DEF: begin
                nxt.tmo_run = 1'b1;
                nxt.remain  = to_ticks(cur.tmo_default);
              end
              pin_ctrl_pkg::CMD_RUN_NEW: begin
                nxt.tmo_run = 1'b1;
                nxt.remain  = to_ticks(hwdata[17:8]);
              end
              pin_ctrl_pkg::CMD_RESUME: begin
                nxt.tmo_run = (cur.remain != 13'h0000);
              end
              pin_ctrl_pkg::CMD_HALT: nxt.tmo_run = 1'b0;
              default: ;
            endcase
          end
        end
        default: ;
      endcase
    end

    // busy from string start to done; start wins
    if (msg_start) nxt.busy = 1'b1;
    else if (msg_done) nxt.busy = 1'b0;

    // queue XOFF on busy entry, XON on ready entry
    if (nxt.busy && !cur.busy) begin
      nxt.tx_pend_busy  = 1'b1;
      nxt.tx_pend_ready = 1'b0;
    end else if (!nxt.busy && cur.busy) begin
      nxt.tx_pend_ready = 1'b1;
    end
    if (cur.tx_valid && tx_ready) nxt.tx_valid = 1'b0;
    if (!cur.ctrl[pin_ctrl_pkg::CTRL_XON_MODE]) begin
      nxt.tx_pend_busy  = 1'b0;
      nxt.tx_pend_ready = 1'b0;
    end else if (!nxt.tx_valid) begin
      if (nxt.tx_pend_busy) begin
        nxt.tx_valid     = 1'b1;
        nxt.tx_char      = pin_ctrl_pkg::CHAR_XOFF;
        nxt.tx_pend_busy = 1'b0;
      end else if (nxt.tx_pend_ready) begin
        nxt.tx_valid      = 1'b1;
        nxt.tx_char       = pin_ctrl_pkg::CHAR_XON;
        nxt.tx_pend_ready = 1'b0;
      end
    end
    nxt.err_force = nxt.ctrl[pin_ctrl_pkg::CTRL_XON_MODE];

    pin_busy_level = nxt.ctrl[pin_ctrl_pkg::CTRL_BUSY_MODE] ? nxt.busy : nxt.pin_on;
    nxt.pin_oe = pin_busy_level ^ nxt.ctrl[pin_ctrl_pkg::CTRL_POS_LOGIC];

    // Read data
    nxt.rdata = 32'h00000000;
    if (bus_take(hsel, hready, htrans) && !hwrite) begin
      case (haddr[7:0])
        pin_ctrl_pkg::OFF_CTRL:   nxt.rdata = {29'h00000000, nxt.ctrl};
        pin_ctrl_pkg::OFF_TMO:    nxt.rdata = {22'h000000, nxt.tmo_default};
        pin_ctrl_pkg::OFF_STATUS: nxt.rdata = {15'h0000, nxt.remain, nxt.busy,
                                              nxt.tmo_run, nxt.locked, nxt.pin_on};
        pin_ctrl_pkg::OFF_TXCHAR: nxt.rdata = {24'h000000, nxt.tx_char};
        default:                  nxt.rdata = 32'h00000000;
      endcase
    end

    if (srst) begin
      nxt = '0;
      nxt.tmo_default = pin_ctrl_pkg::TMO_RESET;
      nxt.pin_oe = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    cur <= nxt;
  end

  assign hrdata           = cur.rdata;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign tx_valid         = cur.tx_valid;
  assign tx_char          = cur.tx_char;
  assign err_report_force = cur.err_force;
  assign pin_oe           = cur.pin_oe;

  // Helpers for assertions
  logic cmd_wr;
  assign cmd_wr = cur.wr_pend && (cur.addr == pin_ctrl_pkg::OFF_CMD);

  // Data phases of control and interval writes
  logic ctrl_wr;
  logic tmo_wr;
  assign ctrl_wr = cur.wr_pend && (cur.addr == pin_ctrl_pkg::OFF_CTRL);
  assign tmo_wr  = cur.wr_pend && (cur.addr == pin_ctrl_pkg::OFF_TMO);

  // Command data phase while the pin accepts configuration
  sequence s_cmd_open;
    cmd_wr && !cur.locked;
  endsequence
  // Busy string finishing with no new string behind it
  sequence s_ready_entry;
    cur.busy && msg_done && !msg_start;
  endsequence

  sequence s_start_run;
    cmd_wr && !cur.locked && (hwdata[3:0] == pin_ctrl_pkg::CMD_RUN_DEF);
  endsequence
  sequence s_running;
    cur.tmo_run;
  endsequence

  AST_LOCK_HOLDS: assert property (@(posedge sys_clk) disable iff (srst)
    cmd_wr && cur.locked && hwdata[3:0] == pin_ctrl_pkg::CMD_ON && !cur.tmo_run
    |=> cur.pin_on == $past(cur.pin_on)) else $error("locked pin changed");
  AST_ON_CMD: assert property (@(posedge sys_clk) disable iff (srst)
    cmd_wr && !cur.locked && hwdata[3:0] == pin_ctrl_pkg::CMD_ON |=> cur.pin_on)
    else $error("on request ignored");
  AST_RUN_NO_ON: assert property (@(posedge sys_clk) disable iff (srst)
    s_start_run ##0 !cur.pin_on |=> !cur.pin_on) else $error("run turned pin on");
  AST_EXPIRE_OFF: assert property (@(posedge sys_clk) disable iff (srst)
    s_running ##0 tick && cur.remain <= 13'h0001 && !cmd_wr |=> !cur.pin_on && !cur.tmo_run)
    else $error("expiry did not clear pin");
  AST_HALT_FREEZE: assert property (@(posedge sys_clk) disable iff (srst)
    !cur.tmo_run && !cmd_wr |=> cur.remain == $past(cur.remain)) else $error("halted timeout moved");
  AST_POLARITY: assert property (@(posedge sys_clk) disable iff (srst)
    !cur.ctrl[pin_ctrl_pkg::CTRL_BUSY_MODE] && !$past(srst) |->
    pin_oe == (cur.pin_on ^ cur.ctrl[pin_ctrl_pkg::CTRL_POS_LOGIC])) else $error("pin polarity wrong");
  AST_BUSY_PIN: assert property (@(posedge sys_clk) disable iff (srst)
    cur.ctrl[pin_ctrl_pkg::CTRL_BUSY_MODE] && !$past(srst) |->
    pin_oe == (cur.busy ^ cur.ctrl[pin_ctrl_pkg::CTRL_POS_LOGIC])) else $error("busy pin wrong");
  AST_BUSY_SET: assert property (@(posedge sys_clk) disable iff (srst)
    msg_start |=> cur.busy) else $error("string did not set busy");
  AST_XOFF_SENT: assert property (@(posedge sys_clk) disable iff (srst)
    cur.ctrl[pin_ctrl_pkg::CTRL_XON_MODE] && msg_start && !cur.busy && !cur.tx_valid && !msg_done
    |=> tx_valid && tx_char == pin_ctrl_pkg::CHAR_XOFF) else $error("xoff not sent");
  AST_ERR_FORCE: assert property (@(posedge sys_clk) disable iff (srst)
    cur.ctrl[pin_ctrl_pkg::CTRL_XON_MODE] |=> err_report_force || !cur.ctrl[pin_ctrl_pkg::CTRL_XON_MODE])
    else $error("error reporting not forced");

  AST_OFF_CMD: assert property (@(posedge sys_clk) disable iff (srst)
    s_cmd_open ##0 hwdata[3:0] == pin_ctrl_pkg::CMD_OFF |=> !cur.pin_on)
    else $error("off request ignored");

  // toggle inverts the present state, even at expiry
  AST_TOGGLE_CMD: assert property (@(posedge sys_clk) disable iff (srst)
    s_cmd_open ##0 hwdata[3:0] == pin_ctrl_pkg::CMD_TOGGLE |=> cur.pin_on != $past(cur.pin_on))
    else $error("toggle request ignored");

  AST_LOCK_SET: assert property (@(posedge sys_clk) disable iff (srst)
    s_cmd_open ##0 hwdata[3:0] == pin_ctrl_pkg::CMD_LOCK |=> cur.locked)
    else $error("lock request ignored");

  // unlock is the one request a locked pin still takes
  AST_UNLOCK_CMD: assert property (@(posedge sys_clk) disable iff (srst)
    cmd_wr && hwdata[3:0] == pin_ctrl_pkg::CMD_UNLOCK |=> !cur.locked)
    else $error("unlock request ignored");

  // locked pin keeps mode and polarity
  AST_LOCK_CTRL: assert property (@(posedge sys_clk) disable iff (srst)
    ctrl_wr && cur.locked |=> cur.ctrl == $past(cur.ctrl))
    else $error("locked control changed");

  // locked pin keeps its default interval
  AST_LOCK_TMO: assert property (@(posedge sys_clk) disable iff (srst)
    tmo_wr && cur.locked |=> cur.tmo_default == $past(cur.tmo_default))
    else $error("locked interval changed");

  // locked pin cannot start its timeout
  AST_LOCK_NO_RUN: assert property (@(posedge sys_clk) disable iff (srst)
    cmd_wr && cur.locked && !cur.tmo_run |=> !cur.tmo_run)
    else $error("locked timeout started");

  AST_HALT_CMD: assert property (@(posedge sys_clk) disable iff (srst)
    s_cmd_open ##0 hwdata[3:0] == pin_ctrl_pkg::CMD_HALT |=> !cur.tmo_run)
    else $error("halt request ignored");

  // halted timeout never turns the pin off
  AST_HALT_KEEPS_PIN: assert property (@(posedge sys_clk) disable iff (srst)
    !cur.tmo_run && !cmd_wr && cur.pin_on |=> cur.pin_on)
    else $error("halted timeout cleared pin");

  AST_RUN_DEF: assert property (@(posedge sys_clk) disable iff (srst)
    s_start_run |=> cur.tmo_run && cur.remain != 13'h0000)
    else $error("default start failed");

  AST_RUN_NEW: assert property (@(posedge sys_clk) disable iff (srst)
    s_cmd_open ##0 hwdata[3:0] == pin_ctrl_pkg::CMD_RUN_NEW |=> cur.tmo_run && cur.remain != 13'h0000)
    else $error("supplied start failed");

  // resume picks up the halted remainder
  AST_RESUME: assert property (@(posedge sys_clk) disable iff (srst)
    s_cmd_open ##0 hwdata[3:0] == pin_ctrl_pkg::CMD_RESUME && cur.remain != 13'h0000 |=> cur.tmo_run)
    else $error("resume failed");

  // one tick off the remainder per time base step
  AST_TICK_DOWN: assert property (@(posedge sys_clk) disable iff (srst)
    s_running ##0 tick && cur.remain > 13'h0001 && !cmd_wr |=> cur.remain == $past(cur.remain) - 13'h0001)
    else $error("countdown step wrong");

  // end of processing returns to ready
  AST_BUSY_CLEAR: assert property (@(posedge sys_clk) disable iff (srst)
    s_ready_entry |=> !cur.busy)
    else $error("busy not cleared");

  // busy stands until processing is done
  AST_BUSY_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
    cur.busy && !msg_done |=> cur.busy)
    else $error("busy dropped early");

  // ready entry offers XON when the line is free
  AST_XON_SENT: assert property (@(posedge sys_clk) disable iff (srst)
    s_ready_entry ##0 cur.ctrl[pin_ctrl_pkg::CTRL_XON_MODE] && !cur.tx_valid && !cur.tx_pend_busy
    |=> tx_valid && tx_char == pin_ctrl_pkg::CHAR_XON) else $error("xon not sent");

  // an offered character stands until taken
  AST_TX_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
    tx_valid && !tx_ready |=> tx_valid && tx_char == $past(tx_char))
    else $error("character withdrawn");

  AST_NO_CHAR: assert property (@(posedge sys_clk) disable iff (srst)
    !cur.ctrl[pin_ctrl_pkg::CTRL_XON_MODE] && !tx_valid |=> !tx_valid)
    else $error("character in pin handshake");

  // output mode ignores the busy condition
  AST_OUT_NO_BUSY: assert property (@(posedge sys_clk) disable iff (srst)
    !cur.ctrl[pin_ctrl_pkg::CTRL_BUSY_MODE] && !ctrl_wr && !cmd_wr && !cur.tmo_run && msg_start
    |=> pin_oe == $past(pin_oe)) else $error("output pin followed busy");

  // busy mode ignores on and off requests
  AST_BUSY_NO_CMD: assert property (@(posedge sys_clk) disable iff (srst)
    cur.ctrl[pin_ctrl_pkg::CTRL_BUSY_MODE] && !ctrl_wr && !msg_start && !msg_done
    |=> pin_oe == $past(pin_oe)) else $error("busy pin followed command");

  AST_RESET_IDLE: assert property (@(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> !pin_oe && !cur.tmo_run && !cur.locked && !cur.busy && !tx_valid)
    else $error("reset state wrong");
endmodule : output_pin_handshake_ctrl

// >>> ctrl_partner.sv
// Model of the controlling PLC or computer on the serial side.
// Assumes one clock shared with the block and a registered ready.
`timescale 1ns/10ps
module ctrl_partner (
  input  wire logic       sys_clk,
  input  wire logic       srst,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_char,
  input  wire logic       stall,
  output logic            tx_ready,
  output logic      [7:0] last_char,
  output logic      [7:0] n_chars
);
  // Receiver takes one char per cycle unless stalled by the bench
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      tx_ready  <= 1'b0;
      last_char <= 8'h00;
      n_chars   <= 8'h00;
    end else begin
      tx_ready <= !stall;
      if (tx_valid && tx_ready) begin
        last_char <= tx_char;
        n_chars   <= n_chars + 8'h01;
      end
    end
  end
endmodule : ctrl_partner

// >>> output_pin_handshake_ctrl_test.sv
// Self-checking bench for the output pin and handshake controller.
// Assumes zero-wait AHB-Lite slave and a shortened 10 ms tick.
`timescale 1ns/10ps
module output_pin_handshake_ctrl_test;
  logic        sys_clk, srst, hsel, hwrite, msg_start, msg_done, stall;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hreadyout, hresp, tx_ready, tx_valid, err_report_force, pin_oe;
  logic [7:0]  tx_char, last_char, n_chars;
  int          n_fail, n_compared, cyc;

  output_pin_handshake_ctrl #(.TICK_CYC(4)) i_dut (
    .sys_clk(sys_clk), .srst(srst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .msg_start(msg_start), .msg_done(msg_done),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_char(tx_char),
    .err_report_force(err_report_force), .pin_oe(pin_oe));

  ctrl_partner i_partner (
    .sys_clk(sys_clk), .srst(srst), .tx_valid(tx_valid), .tx_char(tx_char), .stall(stall),
    .tx_ready(tx_ready), .last_char(last_char), .n_chars(n_chars));

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  task automatic end_of_test;
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test

  // Hang guard, well above the sequence length
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // One single AHB-Lite word transfer; read data lands in rdat
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rdat = hrdata;
  endtask : acc

  task automatic cmd(input logic [31:0] d);
    acc(1'b1, pin_ctrl_pkg::OFF_CMD, d);
  endtask : cmd

  task automatic w(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : w

  // Single-cycle pulse on start or done
  task automatic pulse(input logic done);
    @(posedge sys_clk);
    if (done) msg_done <= 1'b1;
    else msg_start <= 1'b1;
    @(posedge sys_clk);
    msg_done  <= 1'b0;
    msg_start <= 1'b0;
  endtask : pulse

  initial begin
    sys_clk = 0; srst = 1; hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2;
    hwdata = 0; msg_start = 0; msg_done = 0; stall = 0; n_fail = 0; n_compared = 0; cyc = 0;
    repeat (16) @(posedge sys_clk);
    srst <= 1'b0;
    w(1);
    chk(pin_oe, 0);
    chk(err_report_force, 0);
    chk({30'h00000000, hreadyout, hresp}, 32'h00000002);
    acc(1'b0, pin_ctrl_pkg::OFF_STATUS, 0);
    chk(rdat & 32'h0000000F, 0);
    // Output mode commands, lock and polarity
    cmd(32'h00000001); w(3); chk(pin_oe, 1);
    cmd(32'h00000003); w(3); chk(pin_oe, 0);
    cmd(32'h00000003); w(3); chk(pin_oe, 1);
    cmd(32'h00000004); cmd(32'h00000002); w(3); chk(pin_oe, 1);
    acc(1'b1, pin_ctrl_pkg::OFF_CTRL, 32'h00000002); w(3); chk(pin_oe, 1);
    cmd(32'h00000005); cmd(32'h00000002); w(3); chk(pin_oe, 0);
    acc(1'b1, pin_ctrl_pkg::OFF_CTRL, 32'h00000002); w(3); chk(pin_oe, 1);
    cmd(32'h00000001); w(3); chk(pin_oe, 0);
    cmd(32'h00000002);
    acc(1'b1, pin_ctrl_pkg::OFF_CTRL, 32'h00000000);
    // Timeout from default, from a new value, halt and resume
    acc(1'b1, pin_ctrl_pkg::OFF_TMO, 32'h00000005);  // 10 ticks, outlasts the on request
    cmd(32'h00000006);
    acc(1'b0, pin_ctrl_pkg::OFF_STATUS, 0);
    chk(rdat & 32'h00000005, 32'h00000004);
    cmd(32'h00000001); w(1); chk(pin_oe, 1);
    w(60); chk(pin_oe, 0);
    cmd(32'h00000A07); cmd(32'h00000001); cmd(32'h00000009);
    w(100); chk(pin_oe, 1);
    cmd(32'h00000008); w(100); chk(pin_oe, 0);
    acc(1'b0, 8'h20, 0); chk(rdat, 0);
    // Ready/busy pin in both polarities
    acc(1'b1, pin_ctrl_pkg::OFF_CTRL, 32'h00000001);
    pulse(1'b0); w(3); chk(pin_oe, 1);
    pulse(1'b1); w(3); chk(pin_oe, 0);
    acc(1'b1, pin_ctrl_pkg::OFF_CTRL, 32'h00000003); w(3); chk(pin_oe, 1);
    pulse(1'b0); w(3); chk(pin_oe, 0);
    pulse(1'b1); w(3); chk(pin_oe, 1);
    // XON/XOFF with the receiver stalling; next string waits for XON
    acc(1'b1, pin_ctrl_pkg::OFF_CTRL, 32'h00000004); w(2);
    chk(err_report_force, 1);
    @(posedge sys_clk);
    stall <= 1'b1;
    pulse(1'b0); w(3);
    chk(tx_valid, 1);
    chk(tx_char, 8'h13);
    @(posedge sys_clk);
    stall <= 1'b0;
    w(4); chk(last_char, 8'h13);
    pulse(1'b1); w(6); chk(last_char, 8'h11);
    chk(n_chars, 8'h02);
    // next string only once XON was seen
    if (last_char == 8'h11) pulse(1'b0);
    w(4); chk(n_chars, 8'h03);
    pulse(1'b1); w(6); chk(last_char, 8'h11);
    // Mid-run reset with the pin on: all back to idle
    cmd(32'h00000001); w(2); chk(pin_oe, 1);
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    w(1); chk(pin_oe, 0);
    chk(tx_valid, 0);
    chk(err_report_force, 0);
    acc(1'b0, pin_ctrl_pkg::OFF_STATUS, 0);
    chk(rdat & 32'h0000000F, 0);
    end_of_test();
  end
endmodule : output_pin_handshake_ctrl_test
